// file: vrd_pkg.sv
/*
 * Shared constants of the video controller register write decode:
 * word layout, register map, reset values and steering codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package vrd_pkg;

    // ------------------------------------------------------------
    // Write word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int SEL_MSB = 31;
    localparam int SEL_LSB = 26;
    localparam int SEL_W = 6;
    localparam int UNUSED_MSB = 25;
    localparam int UNUSED_LSB = 24;
    localparam int PAYLOAD_MSB = 23;
    localparam int PAYLOAD_W = 24;
    localparam int REG_W = 13;
    localparam int OFFSET_W = 8;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int LOC_COUNT = 64;
    localparam int REG_COUNT = 46;
    localparam int RESERVED_COUNT = 18;
    localparam logic [7:0] OFFSET_STEP = 8'h04;
    localparam logic [7:0] VIDEO_PALETTE_ENTRY_0 = 8'h00;
    localparam logic [7:0] VIDEO_PALETTE_ENTRY_1 = 8'h04;
    localparam logic [7:0] VIDEO_PALETTE_ENTRY_2 = 8'h08;
    localparam logic [7:0] VIDEO_PALETTE_ENTRY_3 = 8'h0c;
    localparam logic [7:0] VIDEO_PALETTE_ENTRY_4 = 8'h10;
    localparam logic [7:0] VIDEO_PALETTE_ENTRY_5 = 8'h14;
    localparam logic [7:0] STEREO_IMAGE_BASE = 8'h60;
    // Set bit = implemented location, clear bit = reserved location
    localparam logic [63:0] IMPL_MASK = 64'h0003_ffff_ff0f_ffff;
    // Lowest payload bit of each group of registers
    localparam int PAYLOAD_LSB = 0;
    localparam logic [12:0] REG_RESET = 13'h0000;

    // ------------------------------------------------------------
    // Sound steering
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VRD_LEFT_POS,
        VRD_RIGHT_POS,
        VRD_LEFT_NEG,
        VRD_RIGHT_NEG
    } vrd_chan_type;

endpackage

`default_nettype wire

// file: vrd_sound_steer.sv
/*
 * Steers the single sound sink onto one of four channel outputs.
 * Assumes the channel code and sink level come from logic on CLK.
 */
`default_nettype none

module vrd_sound_steer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Steering request
    input wire logic [1:0] chan,
    input wire logic sink,
    // Channel outputs
    output logic [3:0] chan_out
);

    // ------------------------------------------------------------
    // One-hot steering
    // ------------------------------------------------------------
    logic [3:0] chan_next;
    logic [3:0] chan_reg;

    // Exactly one output carries the sink; the others stay idle
    always_comb begin
        chan_next = 4'h0;
        case (vrd_pkg::vrd_chan_type'(chan))
            vrd_pkg::VRD_LEFT_POS: chan_next[0] = sink;
            vrd_pkg::VRD_RIGHT_POS: chan_next[1] = sink;
            vrd_pkg::VRD_LEFT_NEG: chan_next[2] = sink;
            vrd_pkg::VRD_RIGHT_NEG: chan_next[3] = sink;
            default: chan_next = 4'h0;
        endcase
    end

    // Registered so the outputs never glitch between channels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_reg <= 4'h0;
        end else begin
            chan_reg <= chan_next;
        end
    end

    assign chan_out = chan_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    one_output_a: assert property (@(posedge clk) disable iff (rst)
        ##1 $onehot0(chan_out) && (chan_out[$past(chan)] == $past(sink)))
        else $error("sound sink not steered to exactly the chosen output");

endmodule

`default_nettype wire

// file: vrd_regfile.sv
/*
 * Write-only register file of a video and sound controller.
 * A host writes 32-bit words: the top six bits pick the register,
 * bits 25:24 are dead, the low 24 bits carry the payload.
 * Assumes write strobes and data come from logic on CLK, one word per
 * strobe, and that FIFO words are flagged so they bypass this decode.
 */
`default_nettype none

// What this block does
// - Holds 46 write-only registers up to 13 bits; host cannot read them.
// - Video, cursor and sound FIFO words never count as register writes.
// - Register select comes only from word bits 31 to 26.
// - Word bits 25 and 24 are ignored entirely.
// - Payload is taken from word bits 23 to 0.
// - Bit 26 is address LSB, so registers sit four apart in offset.
// - Palette colour entries ascend from offset zero; colour 5 at 0x14.
// - Sound sink drives exactly one of four channel outputs at a time.

module vrd_regfile #(
    parameter int REG_W = vrd_pkg::REG_W,
    parameter logic [63:0] IMPL_MASK = vrd_pkg::IMPL_MASK
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Host write port
    input wire logic WR_STROBE,
    input wire logic FIFO_SELECT,
    input wire logic [31:0] WR_DATA,
    // Internal consumer read port (not visible to the host)
    input wire logic [5:0] USE_SEL,
    output logic [REG_W-1:0] USE_DATA,
    // Sound steering
    input wire logic [2:0] SOUND_IMAGE,
    input wire logic SOUND_SINK,
    output logic left_sound_pos_out,
    output logic right_sound_pos_out,
    output logic left_sound_neg_out,
    output logic right_sound_neg_out
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [REG_W-1:0] regs_mem [vrd_pkg::LOC_COUNT];
    logic [REG_W-1:0] use_data_reg;
    logic [5:0] wr_index;
    logic [7:0] wr_offset;
    logic [REG_W-1:0] wr_payload;
    logic wr_hit;
    logic wr_is_fifo;
    logic wr_mapped;

    // Byte offset of a select field, bit 26 weighing one step of four
    function automatic logic [7:0] offset_of(input logic [5:0] index);
        offset_of = {index, 2'b00};
    endfunction

    // Payload field of a write word; the dead bits never reach it
    function automatic logic [REG_W-1:0] payload_of(input logic [31:0] word);
        logic [23:0] low;
        low = word[vrd_pkg::PAYLOAD_MSB:0];
        payload_of = low[vrd_pkg::PAYLOAD_LSB +: REG_W];
    endfunction

    // Set for a location that holds a register; reserved holes come back clear
    function automatic logic is_mapped(input logic [5:0] index);
        is_mapped = IMPL_MASK[index];
    endfunction

    assign wr_index = WR_DATA[vrd_pkg::SEL_MSB:vrd_pkg::SEL_LSB];
    assign wr_offset = offset_of(wr_index);
    assign wr_payload = payload_of(WR_DATA);

    // ------------------------------------------------------------
    // Write qualification
    // ------------------------------------------------------------
    // A FIFO word shares the data bus but never reaches the register decode
    assign wr_is_fifo = WR_STROBE && FIFO_SELECT;
    // Reserved holes are dropped, so a stray word there cannot disturb anything
    assign wr_mapped = is_mapped(wr_index);
    // Only a strobed register word at a mapped location is taken
    assign wr_hit = WR_STROBE && !FIFO_SELECT && wr_mapped;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Only the selected location is loaded; all others keep their value
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < vrd_pkg::LOC_COUNT; i++) begin
                regs_mem[i] <= vrd_pkg::REG_RESET;
            end
        end else if (wr_hit) begin
            regs_mem[wr_index] <= wr_payload;
        end
    end

    // Internal consumers only; no path leads back to the host bus
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            use_data_reg <= vrd_pkg::REG_RESET;
        end else begin
            use_data_reg <= regs_mem[USE_SEL];
        end
    end

    assign USE_DATA = use_data_reg;

    // ------------------------------------------------------------
    // Sound steering
    // ------------------------------------------------------------
    logic [5:0] image_index;
    logic [3:0] chan_out;

    // The stereo image register of the current channel picks the output
    assign image_index = 6'(vrd_pkg::STEREO_IMAGE_BASE >> 2) + {3'b000, SOUND_IMAGE};

    vrd_sound_steer u_steer (
        .clk(CLK),
        .rst(RST),
        .chan(regs_mem[image_index][1:0]),
        .sink(SOUND_SINK),
        .chan_out(chan_out)
    );

    assign left_sound_pos_out = chan_out[0];
    assign right_sound_pos_out = chan_out[1];
    assign left_sound_neg_out = chan_out[2];
    assign right_sound_neg_out = chan_out[3];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // A word the decode must take: strobed, not a FIFO word, at a mapped location
    sequence reg_write_s;
        WR_STROBE && !FIFO_SELECT && IMPL_MASK[WR_DATA[31:26]];
    endsequence

    // A FIFO word on the shared bus, whatever its top bits say
    sequence fifo_word_s;
        wr_is_fifo;
    endsequence

    // The internal port looks, one clock on, at the location just written
    sequence use_same_s;
        USE_SEL == $past(WR_DATA[31:26]);
    endsequence

    // A register word whose select lands on palette colour 5
    sequence palette_five_s;
        reg_write_s ##0 (offset_of(WR_DATA[31:26]) == vrd_pkg::VIDEO_PALETTE_ENTRY_5);
    endsequence

    // First clock after reset has been let go
    sequence reset_gone_s;
        $fell(RST);
    endsequence

    // The selected location holds the low payload bits one clock later
    reg_update_a: assert property (reg_write_s |=>
        regs_mem[$past(WR_DATA[31:26])] == $past(WR_DATA[12:0]))
        else $error("selected register did not take the payload");

    // The location on USE_SEL keeps its value in a clock that does not write it
    others_hold_a: assert property (
        !(WR_STROBE && !FIFO_SELECT && WR_DATA[31:26] == USE_SEL) ##1 1'b1 |->
        regs_mem[$past(USE_SEL)] == $past(regs_mem[USE_SEL]))
        else $error("unselected register changed");

    // A FIFO word leaves the location its top bits would name untouched
    fifo_bypass_a: assert property (fifo_word_s |=>
        regs_mem[$past(WR_DATA[31:26])] == $past(regs_mem[WR_DATA[31:26]]))
        else $error("fifo word altered a register");

    // Reserved holes keep their cleared value whatever crosses the bus
    reserved_hold_a: assert property (
        !IMPL_MASK[USE_SEL] |-> regs_mem[USE_SEL] == vrd_pkg::REG_RESET)
        else $error("reserved location was written");

    // Offset is always the select field times four
    offset_step_a: assert property (
        wr_offset[1:0] == 2'b00 && wr_offset[7:2] == WR_DATA[31:26])
        else $error("offset not four times the select field");

    // Colour 5 lands in location five
    palette_five_a: assert property (
        palette_five_s |=>
        regs_mem[5] == $past(WR_DATA[12:0]))
        else $error("palette colour 5 not at offset 0x14");

    // Bits 25 and 24 reach neither the select nor the payload
    dead_bits_a: assert property (
        wr_payload == WR_DATA[12:0] && wr_index == WR_DATA[31:26])
        else $error("bits 25 or 24 reached decode or payload");

    // Internal port shows the chosen location one clock later
    use_read_a: assert property (##1 USE_DATA == $past(regs_mem[USE_SEL]))
        else $error("internal read port lags or mismatches");

    // Rewriting a register never lets two sound outputs carry the sink
    steer_path_a: assert property (reg_write_s ##1 1'b1 ##1 1'b1 |->
        $onehot0({left_sound_pos_out, right_sound_pos_out,
                  left_sound_neg_out, right_sound_neg_out}))
        else $error("more than one sound output active");

    // Write, then look at the same place: the payload shows two clocks on
    write_use_a: assert property (reg_write_s ##1 use_same_s |=>
        USE_DATA == $past(WR_DATA[12:0], 2))
        else $error("written payload not seen on the internal port");

    // One clock on, the sink sits on the output picked by the image register selected the clock before
    steer_follow_a: assert property (##1
        chan_out[$past(regs_mem[image_index][1:0])] == $past(SOUND_SINK))
        else $error("sound sink not on the output of the picked image");

    // Leaving reset, the internal port and every sound output start idle
    reset_idle_a: assert property (reset_gone_s |->
        USE_DATA == vrd_pkg::REG_RESET && chan_out == 4'h0)
        else $error("outputs not idle after reset");

    // A changed mask must still leave exactly the stated number of registers
    map_count_a: assert property ($countones(IMPL_MASK) == vrd_pkg::REG_COUNT)
        else $error("register map does not hold the stated count");

endmodule

`default_nettype wire

// file: vrd_host_model.sv
/*
 * Host-side model of the register write port: one word per strobe.
 * Assumes the register file samples the port on the rising clock edge.
 */
`default_nettype none

module vrd_host_model (
    // Clock
    input wire logic clk,
    // Write port
    output var logic wr_strobe,
    output var logic fifo_select,
    output var logic [31:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle port before the first word
    initial begin
        wr_strobe = 1'b0;
        fifo_select = 1'b0;
        wr_data = 32'h0000_0000;
    end

    // Word launched on a falling edge and withdrawn on the next one
    task automatic put(input logic [5:0] sel, input logic [1:0] dead, input logic [23:0] pay, input logic fifo);
        @(negedge clk);
        wr_data = {sel, dead, pay}; // Select on top, offset is select times four
        fifo_select = fifo;
        wr_strobe = 1'b1;
        @(negedge clk);
        wr_strobe = 1'b0;
        // Released bus shows the inverse, so a stale word never looks valid
        wr_data = ~wr_data;
        fifo_select = ~fifo;
    endtask
endmodule

`default_nettype wire

// file: tb.sv
/*
 * Self-checking bench of the write-only register file and sound steering.
 * Assumes the register file design and the host model are compiled first.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] use_sel = 6'h00;
    logic [2:0] sound_image = 3'h0;
    logic sound_sink = 1'b0;
    wire logic wr_strobe;
    wire logic fifo_select;
    wire logic [31:0] wr_data;
    wire logic [12:0] use_data;
    wire logic [3:0] snd;
    int errors = 0;
    int check_count = 0;
    int model [64];
    logic [5:0] rsel;
    logic rfifo;

    // 125 MHz clock
    always #4 clk = ~clk;

    vrd_host_model host_u (.clk(clk), .wr_strobe(wr_strobe), .fifo_select(fifo_select), .wr_data(wr_data));

    vrd_regfile dut_u (.CLK(clk), .RST(rst), .WR_STROBE(wr_strobe), .FIFO_SELECT(fifo_select),
        .WR_DATA(wr_data), .USE_SEL(use_sel), .USE_DATA(use_data), .SOUND_IMAGE(sound_image),
        .SOUND_SINK(sound_sink), .left_sound_pos_out(snd[0]), .right_sound_pos_out(snd[1]),
        .left_sound_neg_out(snd[2]), .right_sound_neg_out(snd[3]));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Single comparison point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One host word; FIFO words and reserved places leave the model alone
    task automatic wr(input logic [5:0] sel, input logic fifo, input logic [23:0] pay);
        host_u.put(sel, 2'($urandom), pay, fifo); // Dead bits random
        if (!fifo && vrd_pkg::IMPL_MASK[sel]) begin
            model[sel] = int'(pay[12:0]);
        end
    endtask

    // Reserved places hold no register, so only mapped ones are compared
    task automatic rd(input logic [5:0] sel);
        use_sel = sel;
        @(posedge clk);
        @(negedge clk);
        if (vrd_pkg::IMPL_MASK[sel]) begin
            check(32'(use_data), 32'(model[sel]));
        end
    endtask

    // Cuts a hang well beyond the roughly 1210 cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h2ab5845b));
        foreach (model[i]) begin
            model[i] = 0;
        end
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd(6'd0); // Cleared by reset
        // Host sets up every display timing register before anything else
        for (int i = 32; i < 50; i++) begin
            wr(6'(i), 1'b0, 24'($urandom));
        end
        wr(vrd_pkg::VIDEO_PALETTE_ENTRY_5[7:2], 1'b0, 24'h00_1abc);
        rd(6'd5); // Colour 5 at offset 0x14
        // Random traffic with FIFO words; register words keep off reserved places
        repeat (300) begin
            rsel = 6'($urandom);
            rfifo = ($urandom % 4) == 0;
            while (!rfifo && !vrd_pkg::IMPL_MASK[rsel]) begin
                rsel = 6'($urandom);
            end
            wr(rsel, rfifo, 24'($urandom));
            rd(6'($urandom));
        end
        for (int i = 0; i < 64; i++) begin
            rd(6'(i)); // Full sweep
        end
        // Reset in mid-run clears every register again
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        foreach (model[i]) begin
            model[i] = 0;
        end
        for (int i = 0; i < 64; i++) begin
            rd(6'(i));
        end
        // Each image register takes every code over four rounds, sink low and high
        for (int c = 0; c < 4; c++) begin
            for (int s = 24; s < 32; s++) begin
                wr(6'(s), 1'b0, {22'($urandom), 2'((s + c) % 4)});
            end
            for (int img = 0; img < 8; img++) begin
                for (int k = 0; k < 2; k++) begin
                    sound_image = 3'(img);
                    sound_sink = k[0];
                    @(posedge clk);
                    @(negedge clk);
                    check(32'(snd), (k == 1) ? (32'h1 << (model[24 + img] % 4)) : 32'h0);
                end
            end
        end
        end_of_test();
    end
endmodule

`default_nettype wire
